// ---- shared/arb_regs.svh ----
// Constants for the converter result buffer and sequencer
//
// Behaviour
// - The samples-per-interrupt count sets the interrupt flag; the interrupt line follows it only while enabled.
// - With scanning on, the scan list restarts at its first entry when the samples-per-interrupt count completes.
// - With DMA buffer mode off, the write pointer returns to buffer zero at each samples-per-interrupt boundary.
// - With DMA buffer mode on, the samples-per-interrupt count decides when the DMA address advances.
// - In DMA buffer mode results land only in buffer zero; the DMA address advances once the last result of each samples-per-interrupt count is taken.
// - With DMA buffer mode off, sixteen result buffers fill in sequence, whatever analog input was converted.
// - The done flag clears at conversion start or on software clear, sets at conversion end, and holds through the sample phase.
`ifndef ARB_REGS_SVH
`define ARB_REGS_SVH

// ==========================================================
// Widths and depths
`define ARB_RESULT_W 12
`define ARB_BUF_DEPTH 16
`define ARB_BUF_IDX_W 4
`define ARB_FIFO_DEPTH 8
`define ARB_SAMPLES_PER_INTERRUPT_COUNT_W 5
`define ARB_CHAN_W 5
`define ARB_SCAN_W 32
`define ARB_DMA_ADDR_W 8

// ==========================================================
// Reset values
`define ARB_RST_PTR 4'h0
`define ARB_RST_CNT 5'h00
`define ARB_RST_CHAN 5'h00
`define ARB_RST_ADDR 8'h00

`endif

// ---- shared/arb_pkg.sv ----
// Types shared by the converter result buffer and sequencer
`include "arb_regs.svh"
package arb_pkg;
   typedef logic [`ARB_RESULT_W-1:0] arb_result_t;
   typedef logic [`ARB_CHAN_W-1:0] arb_chan_t;
   typedef enum logic {ARB_MODE_BUFFERED, ARB_MODE_DMA} arb_mode_t;
endpackage

// ---- shared/arb_stream_if.sv ----
// Valid/ready stream carrier between the block's own modules
`timescale 1ns/1ps
interface arb_stream_if #(parameter int WIDTH = 12);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ---- hdl/arb_fifo.sv ----
// Synchronous FIFO with registered full and empty flags
`timescale 1ns/1ps
module arb_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8
) (
   input wire logic i_core_clk,  // Core clock
   input wire logic i_sys_rst,   // Synchronous reset, active high
   arb_stream_if.snk wr,         // Filling side
   arb_stream_if.src rd          // Draining side
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wptr_r;
   logic [AW-1:0] rptr_r;
   logic [AW:0] cnt_r;
   logic full_r;
   logic empty_r;
   logic room_r;
   logic push;
   logic pop;

   // Handshakes on both sides
   assign push = wr.valid & room_r;
   assign pop = ~empty_r & rd.ready;
   assign wr.ready = room_r;
   assign rd.valid = ~empty_r;
   assign rd.data = mem[rptr_r];

   // ==========================================================
   // Storage
   always_ff @(posedge i_core_clk) begin
      if (push) begin
         mem[wptr_r] <= wr.data;
      end
   end

   // Pointers wrap at the depth
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         wptr_r <= '0;
         rptr_r <= '0;
      end else begin
         if (push) begin
            wptr_r <= (wptr_r == AW'(DEPTH - 1)) ? '0 : AW'(wptr_r + 1'b1);
         end
         if (pop) begin
            rptr_r <= (rptr_r == AW'(DEPTH - 1)) ? '0 : AW'(rptr_r + 1'b1);
         end
      end
   end

   // Fill level and its flags
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         cnt_r <= '0;
         full_r <= 1'b0;
         empty_r <= 1'b1;
         room_r <= 1'b1;
      end else begin
         cnt_r <= (AW+1)'(cnt_r + push - pop);
         room_r <= ((AW+1)'(cnt_r + push - pop) != (AW+1)'(DEPTH));
         full_r <= ((AW+1)'(cnt_r + push - pop) == (AW+1)'(DEPTH));
         empty_r <= ((AW+1)'(cnt_r + push - pop) == '0);
      end
   end

   AST_FIFO_NO_OVERFLOW: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
      cnt_r <= (AW+1)'(DEPTH) && full_r == !room_r)
      else $error("FIFO full flag without full count");
endmodule

// ---- hdl/arb_core.sv ----
// Converter result buffer, conversion counter and scan sequencer
`timescale 1ns/1ps
`include "arb_regs.svh"
module arb_core (
   input wire logic i_core_clk,                               // Core clock, 20 MHz
   input wire logic i_sys_rst,                                // Synchronous reset, active high
   input wire logic i_result_valid,                           // Front end result valid
   input wire arb_pkg::arb_result_t i_result_data,            // Front end result word
   output logic o_result_ready,                               // Result FIFO has room
   input wire logic i_conv_start,                             // Conversion begins, pulse
   input wire logic i_conv_end,                               // Conversion finishes, pulse
   input wire logic i_done_sw_clear,                          // Software clears done flag
   input wire logic [`ARB_SAMPLES_PER_INTERRUPT_COUNT_W-1:0] i_samples_per_interrupt_count, // Conversions per event minus one
   input wire logic i_int_enable,                             // Interrupt enable
   input wire logic i_int_flag_clear,                         // Software clears interrupt flag
   input wire logic i_channel_scan_enable,                    // Scan the channel list
   input wire logic [15:0] i_scan_select_low,                 // Scan list, inputs 0 to 15
   input wire logic [15:0] i_scan_select_high,                // Scan list, inputs 16 to 31
   input wire arb_pkg::arb_chan_t i_fixed_channel,            // Channel when not scanning
   input wire arb_pkg::arb_mode_t i_dma_buffer_mode_enable,   // DMA buffer mode
   input wire logic [`ARB_BUF_IDX_W-1:0] i_buf_rd_index,      // Result buffer read index
   input wire logic i_dma_ready,                              // DMA takes the result
   output arb_pkg::arb_result_t o_buf_rd_data,                // Result buffer read data
   output arb_pkg::arb_chan_t o_scan_channel,                 // Channel to convert next
   output logic o_conv_done,                                  // Conversion-done flag
   output logic o_int_flag,                                   // Converter interrupt flag
   output logic o_irq,                                        // Interrupt request
   output logic o_dma_valid,                                  // DMA result pending
   output arb_pkg::arb_result_t o_dma_data,                   // DMA result word
   output logic [`ARB_DMA_ADDR_W-1:0] o_dma_addr,             // DMA address offset
   output logic [`ARB_BUF_IDX_W-1:0] o_wr_ptr                 // Result write pointer
);
   import arb_pkg::*;

   arb_result_t buf_r [`ARB_BUF_DEPTH];
   logic [`ARB_SAMPLES_PER_INTERRUPT_COUNT_W-1:0] cnt_r;
   logic [`ARB_SCAN_W-1:0] scan_mask;
   logic dma_mode;
   logic pop;
   logic last;
   logic int_nxt;
   arb_chan_t first_chan;
   arb_chan_t next_chan;

   arb_stream_if #(.WIDTH(`ARB_RESULT_W)) in_s ();
   arb_stream_if #(.WIDTH(`ARB_RESULT_W)) out_s ();

   // First selected channel at or after a start index, wrapping
   function automatic arb_chan_t next_set(input logic [`ARB_SCAN_W-1:0] mask, input arb_chan_t start);
      arb_chan_t idx;
      arb_chan_t found;
      logic hit;
      found = '0;
      hit = 1'b0;
      for (int i = 0; i < `ARB_SCAN_W; i++) begin
         idx = arb_chan_t'(start + arb_chan_t'(i));
         if (!hit && mask[idx]) begin
            found = idx;
            hit = 1'b1;
         end
      end
      return found;
   endfunction

   // ==========================================================
   // Result FIFO in the data path
   assign in_s.valid = i_result_valid;
   assign in_s.data = i_result_data;

   arb_fifo #(.WIDTH(`ARB_RESULT_W), .DEPTH(`ARB_FIFO_DEPTH)) u_fifo (
      .i_core_clk (i_core_clk),
      .i_sys_rst (i_sys_rst),
      .wr (in_s.snk),
      .rd (out_s.src)
   );

   // Room flag taken straight from the FIFO's room flop
   assign o_result_ready = in_s.ready;

   // A completed conversion drains one word; DMA mode waits for the reader
   assign dma_mode = (i_dma_buffer_mode_enable == ARB_MODE_DMA);
   assign out_s.ready = ~dma_mode | ~o_dma_valid | i_dma_ready;
   assign pop = out_s.valid & out_s.ready;
   assign last = (cnt_r == i_samples_per_interrupt_count);
   assign scan_mask = {i_scan_select_high, i_scan_select_low};
   assign first_chan = next_set(scan_mask, '0);
   assign next_chan = next_set(scan_mask, arb_chan_t'(o_scan_channel + 1'b1));

   // ==========================================================
   // Conversion counter against the samples-per-interrupt count
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         cnt_r <= `ARB_RST_CNT;
      end else if (pop) begin
         cnt_r <= last ? `ARB_RST_CNT : `ARB_SAMPLES_PER_INTERRUPT_COUNT_W'(cnt_r + 1'b1);
      end
   end

   // Write pointer: sequential fill, zero in DMA mode
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_wr_ptr <= `ARB_RST_PTR;
      end else if (pop) begin
         if (dma_mode || last) begin
            o_wr_ptr <= `ARB_RST_PTR;
         end else begin
            o_wr_ptr <= `ARB_BUF_IDX_W'(o_wr_ptr + 1'b1);
         end
      end
   end

   // Result buffers, buffer zero only in DMA mode
   always_ff @(posedge i_core_clk) begin
      if (pop) begin
         buf_r[dma_mode ? `ARB_RST_PTR : o_wr_ptr] <= out_s.data;
      end
   end

   // Registered read port
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_buf_rd_data <= '0;
      end else begin
         o_buf_rd_data <= buf_r[i_buf_rd_index];
      end
   end

   // ==========================================================
   // Interrupt flag: set wins over clear, line gated by enable
   assign int_nxt = (pop && last) ? 1'b1 : (i_int_flag_clear ? 1'b0 : o_int_flag);
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_int_flag <= 1'b0;
         o_irq <= 1'b0;
      end else begin
         o_int_flag <= int_nxt;
         o_irq <= int_nxt & i_int_enable;
      end
   end

   // Scan sequencer: start on the list, restart it at the count boundary
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_scan_channel <= `ARB_RST_CHAN;
      end else if (!i_channel_scan_enable) begin
         o_scan_channel <= i_fixed_channel;
      end else if (pop) begin
         o_scan_channel <= last ? first_chan : next_chan;
      end else if (!scan_mask[o_scan_channel]) begin
         o_scan_channel <= first_chan;
      end
   end

   // DMA hand-off of buffer zero, address stepped per count
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_dma_valid <= 1'b0;
         o_dma_data <= '0;
         o_dma_addr <= `ARB_RST_ADDR;
      end else begin
         if (pop && dma_mode) begin
            o_dma_valid <= 1'b1;
            o_dma_data <= out_s.data;
         end else if (i_dma_ready) begin
            o_dma_valid <= 1'b0;
         end
         if (o_dma_valid && i_dma_ready && dma_mode && cnt_r == `ARB_RST_CNT) begin
            o_dma_addr <= `ARB_DMA_ADDR_W'(o_dma_addr + 1'b1);
         end
      end
   end

   // Done flag: conversion end wins, start or software clears
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_conv_done <= 1'b0;
      end else if (i_conv_end) begin
         o_conv_done <= 1'b1;
      end else if (i_conv_start || i_done_sw_clear) begin
         o_conv_done <= 1'b0;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);

   AST_INT_SET: assert property (pop && last |=> o_int_flag)
      else $error("interrupt flag not set at count boundary");
   AST_IRQ_GATE: assert property (o_irq |-> o_int_flag && $past(i_int_enable))
      else $error("interrupt line raised without enable or flag");
   AST_SCAN_RESTART: assert property (pop && last && i_channel_scan_enable
      |=> o_scan_channel == $past(first_chan))
      else $error("scan list did not restart");
   AST_PTR_RESET: assert property (pop && last && !dma_mode |=> o_wr_ptr == `ARB_RST_PTR)
      else $error("write pointer not reset at count boundary");
   AST_DMA_ADDR_HOLD: assert property (o_dma_valid && !i_dma_ready |=> $stable(o_dma_addr))
      else $error("DMA address moved while result pending");
   AST_DMA_ZERO: assert property (pop && dma_mode |=> o_wr_ptr == `ARB_RST_PTR && buf_r[0] == $past(out_s.data))
      else $error("DMA mode result not in buffer zero");
   AST_SEQ_FILL: assert property (pop && !dma_mode && !last
      |=> o_wr_ptr == `ARB_BUF_IDX_W'($past(o_wr_ptr) + 1'b1))
      else $error("buffers not filled in sequence");
   AST_DMA_HOLD: assert property (o_dma_valid && !i_dma_ready |=> o_dma_valid && $stable(o_dma_data))
      else $error("pending DMA result lost");
   AST_DONE_SET: assert property (i_conv_end |=> o_conv_done ##0 (o_conv_done || i_conv_start))
      else $error("done flag not set at conversion end");
   AST_DONE_HOLD: assert property (o_conv_done && !i_conv_start && !i_done_sw_clear |=> o_conv_done)
      else $error("done flag dropped without conversion start");
   AST_IRQ_SET: assert property (pop && last && i_int_enable |=> o_irq)
      else $error("interrupt line not raised at count boundary");
   AST_INT_HOLD: assert property (o_int_flag && !i_int_flag_clear |=> o_int_flag)
      else $error("interrupt flag dropped without clear");
   AST_DMA_PENDING: assert property (pop && dma_mode |=> o_dma_valid && o_dma_data == $past(out_s.data))
      else $error("DMA result not offered");
   AST_DONE_CLEAR: assert property (i_conv_start && !i_conv_end |=> !o_conv_done)
      else $error("done flag not cleared at conversion start");

   COV_INT: cover property (pop && last && i_int_enable ##1 o_irq);
   COV_DMA_STALL: cover property (o_dma_valid && !i_dma_ready [*3]);
   COV_FIFO_FULL: cover property (!o_result_ready && i_result_valid);
   COV_SCAN_WRAP: cover property (pop && last && i_channel_scan_enable);
endmodule

// ---- tb/arb_dma_reader.sv ----
// Reader model on the far side: DMA controller or CPU taking results
`timescale 1ns/1ps
module arb_dma_reader (
   input wire logic i_core_clk, // Core clock
   input wire logic i_sys_rst,  // Synchronous reset
   input wire logic i_hold,     // Stop taking results
   input wire logic i_slow,     // Take one result in four cycles
   output logic o_dma_ready     // Result taken this cycle
);
   logic [1:0] pace_r;
   // ==========================================================
   // Pacing counter for the slow reader
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         pace_r <= 2'h0;
      end else begin
         pace_r <= pace_r + 2'h1;
      end
   end
   // Takes buffer zero before the next result may land
   assign o_dma_ready = !i_hold && (!i_slow || pace_r == 2'h0);
endmodule

// ---- tb/tb_top.sv ----
// Self-checking testbench of the converter result buffer and sequencer
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin num_errors++; \
   $display("Error %s expected %h seen %h", nm, ex, gt); end end
module tb_top;
   import arb_pkg::*;
   logic i_core_clk = 0, i_sys_rst = 1, i_result_valid = 0, i_conv_start = 0, i_conv_end = 0;
   logic i_done_sw_clear = 0, i_int_enable = 0, i_int_flag_clear = 0, i_channel_scan_enable = 0;
   logic [4:0] i_samples_per_interrupt_count = 5'h00;
   logic [15:0] i_scan_select_low = 16'h0000, i_scan_select_high = 16'h0000, lf = 16'hd42c;
   logic [3:0] i_buf_rd_index = 4'h0;
   arb_result_t i_result_data = 12'h000, o_buf_rd_data, o_dma_data, words[16];
   arb_chan_t i_fixed_channel = 5'h00, o_scan_channel;
   arb_mode_t i_dma_buffer_mode_enable = ARB_MODE_BUFFERED;
   logic o_result_ready, i_dma_ready, o_conv_done, o_int_flag, o_irq, o_dma_valid, hold = 0, slow = 0;
   logic [7:0] o_dma_addr;
   logic [3:0] o_wr_ptr;
   arb_result_t exp_q[$], exp_w;
   int num_errors = 0, n_checks = 0, k, acc;
   bit ok;
   arb_core dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_result_valid(i_result_valid),
      .i_result_data(i_result_data), .o_result_ready(o_result_ready), .i_conv_start(i_conv_start),
      .i_conv_end(i_conv_end), .i_done_sw_clear(i_done_sw_clear),
      .i_samples_per_interrupt_count(i_samples_per_interrupt_count), .i_int_enable(i_int_enable),
      .i_int_flag_clear(i_int_flag_clear), .i_channel_scan_enable(i_channel_scan_enable),
      .i_scan_select_low(i_scan_select_low), .i_scan_select_high(i_scan_select_high),
      .i_fixed_channel(i_fixed_channel), .i_dma_buffer_mode_enable(i_dma_buffer_mode_enable),
      .i_buf_rd_index(i_buf_rd_index), .i_dma_ready(i_dma_ready), .o_buf_rd_data(o_buf_rd_data),
      .o_scan_channel(o_scan_channel), .o_conv_done(o_conv_done), .o_int_flag(o_int_flag),
      .o_irq(o_irq), .o_dma_valid(o_dma_valid), .o_dma_data(o_dma_data), .o_dma_addr(o_dma_addr),
      .o_wr_ptr(o_wr_ptr));
   arb_dma_reader reader (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_hold(hold),
      .i_slow(slow), .o_dma_ready(i_dma_ready));
   // ==========================================================
   // Clock, LFSR and closing
   always #25 i_core_clk = ~i_core_clk;
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   task automatic end_of_test;
      $display("Checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Offer one random word, wait up to limit edges for it to be taken
   task automatic push_word(input int limit, output bit ok);
      lf = lfsr(lf);
      i_result_valid = 1'b1;
      i_result_data = lf[11:0];
      ok = 0;
      for (int t = 0; t < limit && !ok; t++) begin
         @(posedge i_core_clk);
         ok = (o_result_ready === 1'b1);
      end
      if (ok && i_dma_buffer_mode_enable == ARB_MODE_DMA) exp_q.push_back(i_result_data);
      @(negedge i_core_clk);
   endtask
   // ==========================================================
   // Monitor: compare each word the reader takes with the oldest note
   always @(posedge i_core_clk) begin
      if (!i_sys_rst && o_dma_valid === 1'b1 && i_dma_ready === 1'b1) begin
         exp_w = (exp_q.size() > 0) ? exp_q.pop_front() : 12'hxxx;
         `CHK("dma_data", exp_w, o_dma_data)
      end
   end
   // Watchdog, about fifty times the expected run
   initial begin
      #(20000 * 50);
      num_errors++;
      end_of_test();
   end
   // ==========================================================
   // Main sequence
   initial begin
      repeat (16) @(negedge i_core_clk);
      i_sys_rst = 0;
      `CHK("wr_ptr", 4'h0, o_wr_ptr)
      `CHK("int_flag", 1'b0, o_int_flag)
      // Buffered fill of all sixteen buffers, scanning inputs 3, 9 and 20
      i_samples_per_interrupt_count = 5'h0f;
      i_channel_scan_enable = 1;
      i_scan_select_low = 16'h0208;
      i_scan_select_high = 16'h0010;
      i_int_enable = 1;
      for (k = 1; k <= 16; k++) begin
         push_word(20, ok);
         words[k - 1] = i_result_data;
         i_result_valid = 0;
         repeat (3) @(negedge i_core_clk);
         `CHK("wr_ptr", 4'(k % 16), o_wr_ptr)
         `CHK("scan_chan", (k % 3 == 0 || k == 16) ? 5'h03 : (k % 3 == 1) ? 5'h09 : 5'h14, o_scan_channel)
         `CHK("int_flag", 1'(k == 16), o_int_flag)
      end
      `CHK("irq", 1'b1, o_irq)
      for (k = 0; k < 16; k++) begin
         i_buf_rd_index = 4'(k);
         @(negedge i_core_clk);
         `CHK("buf_rd", words[k], o_buf_rd_data)
      end
      // Flag clear, then one conversion per event with interrupt masked
      i_int_flag_clear = 1;
      @(negedge i_core_clk);
      i_int_flag_clear = 0;
      `CHK("int_flag", 1'b0, o_int_flag)
      i_samples_per_interrupt_count = 5'h00;
      i_int_enable = 0;
      i_channel_scan_enable = 0;
      i_fixed_channel = 5'h07;
      push_word(20, ok);
      i_result_valid = 0;
      repeat (3) @(negedge i_core_clk);
      `CHK("int_flag", 1'b1, o_int_flag)
      `CHK("irq", 1'b0, o_irq)
      `CHK("wr_ptr", 4'h0, o_wr_ptr)
      `CHK("scan_chan", 5'h07, o_scan_channel)
      // Conversion-done flag life cycle
      i_conv_end = 1;
      @(negedge i_core_clk);
      i_conv_end = 0;
      repeat (5) @(negedge i_core_clk);
      `CHK("done", 1'b1, o_conv_done)
      i_conv_start = 1;
      @(negedge i_core_clk);
      `CHK("done", 1'b0, o_conv_done)
      i_conv_end = 1;
      @(negedge i_core_clk);
      i_conv_start = 0;
      i_conv_end = 0;
      `CHK("done", 1'b1, o_conv_done)
      i_done_sw_clear = 1;
      @(negedge i_core_clk);
      i_done_sw_clear = 0;
      `CHK("done", 1'b0, o_conv_done)
      // DMA mode: stalled reader until the FIFO refuses, then a slow drain
      i_samples_per_interrupt_count = 5'h1f;
      i_dma_buffer_mode_enable = ARB_MODE_DMA;
      hold = 1;
      acc = 0;
      ok = 1;
      while (ok && acc < 20) begin
         push_word(4, ok);
         acc += int'(ok);
      end
      i_result_valid = 0;
      `CHK("fill_refused", 1'b1, 1'(acc >= 8 && acc <= 10))
      hold = 0;
      slow = 1;
      while (acc < 64) begin
         push_word(50, ok);
         acc += int'(ok);
      end
      i_result_valid = 0;
      for (k = 0; k < 400 && exp_q.size() > 0; k++) @(negedge i_core_clk);
      repeat (3) @(negedge i_core_clk);
      `CHK("dma_drained", 0, exp_q.size())
      `CHK("dma_addr", 8'h02, o_dma_addr)
      `CHK("wr_ptr", 4'h0, o_wr_ptr)
      end_of_test();
   end
endmodule
